// [design/swd_top.sv]
// Function
// - input low long enough delatches or sleeps
// - watchdog expiry forces fail-safe operation
// - watchdog runs only while disable bit zero
// - interval starts at device reset rising edge
// - retry period chosen by two-bit field
// - serial input sampled on falling clock edge
// - serial output launched on rising clock edge
// - serial output driven once frame select low
// - serial output released when frame select high
// - long device reset switches serial channels off
// - protections stay active at any switching rate
// - toggle bit must alternate within watchdog interval
// - reset clears serial registers, sleep after inputs
// - every serial transfer is 16-bit words
module swd_top #(
  parameter int CNT_W = swd_pkg::CNT_W,
  parameter int LOW_TIME_CYC = swd_pkg::LOW_TIME_CYC,
  parameter int LINK_LOSS_CYC = swd_pkg::LINK_LOSS_CYC,
  parameter int RETRY_CYC_00 = swd_pkg::RETRY_CYC_00,
  parameter int RETRY_CYC_01 = swd_pkg::RETRY_CYC_01,
  parameter int RETRY_CYC_10 = swd_pkg::RETRY_CYC_10,
  parameter int RETRY_CYC_11 = swd_pkg::RETRY_CYC_11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic active_low_device_reset,
  input wire logic sclk,
  input wire logic frame_select_low,
  input wire logic serial_in,
  input wire logic [swd_pkg::CH_COUNT-1:0] direct_in,
  input wire logic [swd_pkg::CH_COUNT-1:0] over_current,
  output logic serial_out,
  output logic serial_out_en,
  output logic [swd_pkg::CH_COUNT-1:0] high_side_outputs,
  output logic fail_safe_mode,
  output logic sleep_mode
);

  localparam int CH = swd_pkg::CH_COUNT;
  localparam int RW = swd_pkg::RST_CNT_W;
  localparam logic [CNT_W-1:0] LOW_LIM = CNT_W'(LOW_TIME_CYC);
  localparam logic [CNT_W-1:0] LOSS_LAST = CNT_W'(LINK_LOSS_CYC - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST_00 = CNT_W'(RETRY_CYC_00 - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST_01 = CNT_W'(RETRY_CYC_01 - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST_10 = CNT_W'(RETRY_CYC_10 - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST_11 = CNT_W'(RETRY_CYC_11 - 1);
  localparam logic [RW-1:0] RLOW_LIM = RW'(swd_pkg::RESET_LOW_CYC);

  // synchronisers
  logic active_low_device_reset_meta;
  logic active_low_device_reset_sync;
  logic active_low_device_reset_prev;
  logic cs_meta;
  logic cs_sync;
  logic tgl_meta;
  logic tgl_sync;
  logic tgl_prev;
  logic [CH-1:0] din_meta;
  logic [CH-1:0] din_sync;
  logic [CH-1:0] oc_meta;
  logic [CH-1:0] oc_sync;

  // word path and control state
  logic active_low_device_reset_rise;
  logic word_evt;
  logic valid_act;
  logic [2:0] word_sel;
  logic [RW-1:0] rlow_cnt;
  logic [RW-1:0] next_rlow_cnt;
  logic rlow_done;
  logic [CH-1:0] spi_on;
  logic [CH-1:0] next_spi_on;
  logic watchdog_disable_bit;
  logic next_watchdog_disable_bit;
  logic retry_en;
  logic next_retry_en;
  logic [swd_pkg::PERIOD_W-1:0] retry_period;
  logic [swd_pkg::PERIOD_W-1:0] next_retry_period;
  logic ref_bit;
  logic next_ref_bit;
  logic have_ref;
  logic next_have_ref;

  // watchdog
  swd_pkg::swd_wd_state_t wd_state;
  swd_pkg::swd_wd_state_t next_wd_state;
  logic [CNT_W-1:0] wd_cnt;
  logic [CNT_W-1:0] next_wd_cnt;
  logic next_fail_safe_mode;

  // channels
  logic [CH-1:0] low_done;
  logic [CH-1:0] fault;
  logic [CH-1:0] next_hs;
  logic next_sleep_mode;
  logic next_serial_out_en;
  logic [CNT_W-1:0] retry_last;

  swd_link_if lnk_bus ();

  swd_spi_link u_link (
    .rst(rst),
    .sclk(sclk),
    .frame_select_low(frame_select_low),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .lnk(lnk_bus.link)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      active_low_device_reset_meta <= 1'h0;
      active_low_device_reset_sync <= 1'h0;
      active_low_device_reset_prev <= 1'h0;
      cs_meta <= 1'h1;
      cs_sync <= 1'h1;
      tgl_meta <= 1'h0;
      tgl_sync <= 1'h0;
      tgl_prev <= 1'h0;
      din_meta <= '0;
      din_sync <= '0;
      oc_meta <= '0;
      oc_sync <= '0;
    end else begin
      active_low_device_reset_meta <= active_low_device_reset;
      active_low_device_reset_sync <= active_low_device_reset_meta;
      active_low_device_reset_prev <= active_low_device_reset_sync;
      cs_meta <= frame_select_low;
      cs_sync <= cs_meta;
      tgl_meta <= lnk_bus.rx_toggle;
      tgl_sync <= tgl_meta;
      tgl_prev <= tgl_sync;
      din_meta <= direct_in;
      din_sync <= din_meta;
      oc_meta <= over_current;
      oc_sync <= oc_meta;
    end
  end

  assign active_low_device_reset_rise = active_low_device_reset_sync & ~active_low_device_reset_prev;
  // the word register stays put for a whole word time after its toggle flips
  assign word_evt = tgl_sync ^ tgl_prev;
  assign word_sel = lnk_bus.rx_word[swd_pkg::SEL_HI:swd_pkg::SEL_LO];
  assign valid_act = word_evt & (~have_ref | (lnk_bus.rx_word[swd_pkg::TOGGLE_POS] != ref_bit));
  assign rlow_done = (rlow_cnt == RLOW_LIM);

  // serial control register and toggle reference
  always_comb begin
    next_rlow_cnt = rlow_cnt;
    next_spi_on = spi_on;
    next_watchdog_disable_bit = watchdog_disable_bit;
    next_retry_en = retry_en;
    next_retry_period = retry_period;
    next_ref_bit = ref_bit;
    next_have_ref = have_ref;
    if (active_low_device_reset_sync) begin
      next_rlow_cnt = '0;
    end else if (!rlow_done) begin
      next_rlow_cnt = rlow_cnt + 1'h1;
    end
    if (rlow_done) begin
      // a short glitch on the reset pin must not wipe the configuration
      next_spi_on = '0;
      next_watchdog_disable_bit = swd_pkg::WATCHDOG_DISABLE_BIT_RESET;
      next_retry_en = swd_pkg::RETRY_EN_RESET;
      next_retry_period = swd_pkg::PERIOD_RESET;
    end else if (word_evt && active_low_device_reset_sync && word_sel == swd_pkg::SEL_CTRL) begin
      next_spi_on = lnk_bus.rx_word[swd_pkg::ON_LO +: CH];
      next_watchdog_disable_bit = lnk_bus.rx_word[swd_pkg::WATCHDOG_DISABLE_BIT_POS];
      next_retry_en = lnk_bus.rx_word[swd_pkg::RETRY_EN_POS];
      next_retry_period = lnk_bus.rx_word[swd_pkg::PERIOD_LO +: swd_pkg::PERIOD_W];
    end
    if (active_low_device_reset_rise) begin
      next_have_ref = 1'h0;
    end else if (valid_act) begin
      next_ref_bit = lnk_bus.rx_word[swd_pkg::TOGGLE_POS];
      next_have_ref = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rlow_cnt <= '0;
      spi_on <= '0;
      watchdog_disable_bit <= swd_pkg::WATCHDOG_DISABLE_BIT_RESET;
      retry_en <= swd_pkg::RETRY_EN_RESET;
      retry_period <= swd_pkg::PERIOD_RESET;
      ref_bit <= 1'h0;
      have_ref <= 1'h0;
    end else begin
      rlow_cnt <= next_rlow_cnt;
      spi_on <= next_spi_on;
      watchdog_disable_bit <= next_watchdog_disable_bit;
      retry_en <= next_retry_en;
      retry_period <= next_retry_period;
      ref_bit <= next_ref_bit;
      have_ref <= next_have_ref;
    end
  end

  // link-loss watchdog
  always_comb begin
    next_wd_state = wd_state;
    next_wd_cnt = wd_cnt;
    unique case (wd_state)
      swd_pkg::SWD_WD_IDLE: begin
        next_wd_cnt = '0;
        if (active_low_device_reset_rise) begin
          next_wd_state = swd_pkg::SWD_WD_RUN;
        end
      end
      swd_pkg::SWD_WD_RUN: begin
        if (!active_low_device_reset_sync) begin
          next_wd_state = swd_pkg::SWD_WD_IDLE;
        end else if (valid_act || watchdog_disable_bit) begin
          next_wd_cnt = '0;
        end else if (wd_cnt == LOSS_LAST) begin
          next_wd_state = swd_pkg::SWD_WD_FAILSAFE;
        end else begin
          next_wd_cnt = wd_cnt + 1'h1;
        end
      end
      swd_pkg::SWD_WD_FAILSAFE: begin
        next_wd_cnt = '0;
        if (!active_low_device_reset_sync) begin
          next_wd_state = swd_pkg::SWD_WD_IDLE;
        end
      end
      default: begin
        next_wd_state = swd_pkg::SWD_WD_IDLE;
        next_wd_cnt = '0;
      end
    endcase
    next_fail_safe_mode = (next_wd_state == swd_pkg::SWD_WD_FAILSAFE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wd_state <= swd_pkg::SWD_WD_IDLE;
      wd_cnt <= '0;
      fail_safe_mode <= 1'h0;
    end else begin
      wd_state <= next_wd_state;
      wd_cnt <= next_wd_cnt;
      fail_safe_mode <= next_fail_safe_mode;
    end
  end

  always_comb begin
    unique case (retry_period)
      2'h0: retry_last = RETRY_LAST_00;
      2'h1: retry_last = RETRY_LAST_01;
      2'h2: retry_last = RETRY_LAST_10;
      2'h3: retry_last = RETRY_LAST_11;
    endcase
  end

  // per-channel low timer, fault latch and auto-retry
  for (genvar ch = 0; ch < CH; ch++) begin : g_ch
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] next_low_cnt;
    logic [CNT_W-1:0] retry_cnt;
    logic [CNT_W-1:0] next_retry_cnt;
    logic next_fault;
    logic retry_hit;

    assign low_done[ch] = (low_cnt == LOW_LIM);
    assign retry_hit = retry_en & fault[ch] & (retry_cnt == retry_last);

    always_comb begin
      next_low_cnt = low_cnt;
      if (din_sync[ch]) begin
        next_low_cnt = '0;
      end else if (!low_done[ch]) begin
        next_low_cnt = low_cnt + 1'h1;
      end
      next_retry_cnt = '0;
      if (retry_en && fault[ch] && !retry_hit) begin
        next_retry_cnt = retry_cnt + 1'h1;
      end
      // protection acts in every mode and at any switching rate; the new fault wins
      if (oc_sync[ch]) begin
        next_fault = 1'h1;
      end else if (low_done[ch] || retry_hit) begin
        next_fault = 1'h0;
      end else begin
        next_fault = fault[ch];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        low_cnt <= '0;
        retry_cnt <= '0;
        fault[ch] <= 1'h0;
      end else begin
        low_cnt <= next_low_cnt;
        retry_cnt <= next_retry_cnt;
        fault[ch] <= next_fault;
      end
    end

    always_comb begin
      if (fail_safe_mode) begin
        next_hs[ch] = din_sync[ch] & ~fault[ch] & ~next_sleep_mode;
      end else begin
        next_hs[ch] = (din_sync[ch] | spi_on[ch]) & ~fault[ch] & ~next_sleep_mode;
      end
    end
  end

  always_comb begin
    next_sleep_mode = ~active_low_device_reset_sync & (&low_done);
    next_serial_out_en = ~cs_sync;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_side_outputs <= '0;
      sleep_mode <= 1'h0;
      serial_out_en <= 1'h0;
    end else begin
      high_side_outputs <= next_hs;
      sleep_mode <= next_sleep_mode;
      serial_out_en <= next_serial_out_en;
    end
  end

endmodule : swd_top

// [inc/swd_pkg.sv]
package swd_pkg;

  // core clock
  localparam int CLK_MHZ = 100;

  // supervisory times, nominal figures
  localparam int LOW_TIME_MS = 250;
  localparam int LINK_LOSS_MS = 310;
  localparam int RETRY_US_00 = 150000;
  localparam int RETRY_US_01 = 75000;
  localparam int RETRY_US_10 = 37500;
  localparam int RETRY_US_11 = 17700;
  localparam int RESET_LOW_US = 10;

  // derived cycle counts
  localparam int LOW_TIME_CYC = LOW_TIME_MS * 1000 * CLK_MHZ;
  localparam int LINK_LOSS_CYC = LINK_LOSS_MS * 1000 * CLK_MHZ;
  localparam int RETRY_CYC_00 = RETRY_US_00 * CLK_MHZ;
  localparam int RETRY_CYC_01 = RETRY_US_01 * CLK_MHZ;
  localparam int RETRY_CYC_10 = RETRY_US_10 * CLK_MHZ;
  localparam int RETRY_CYC_11 = RETRY_US_11 * CLK_MHZ;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;

  // widths
  localparam int CH_COUNT = 2;
  localparam int CNT_W = 25;
  localparam int RST_CNT_W = 10;
  localparam int WORD_BITS = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;

  // serial word layout
  localparam int TOGGLE_POS = 15;
  localparam int SEL_HI = 14;
  localparam int SEL_LO = 12;
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam int ON_LO = 0;
  localparam int WATCHDOG_DISABLE_BIT_POS = 2;
  localparam int RETRY_EN_POS = 3;
  localparam int PERIOD_LO = 4;
  localparam int PERIOD_W = 2;

  // control reset values
  localparam logic WATCHDOG_DISABLE_BIT_RESET = 1'h0;
  localparam logic RETRY_EN_RESET = 1'h0;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 2'h0;

  typedef enum logic [1:0] {
    SWD_WD_IDLE,
    SWD_WD_RUN,
    SWD_WD_FAILSAFE
  } swd_wd_state_t;

endpackage : swd_pkg

// [inc/swd_link_if.sv]
interface swd_link_if;
  logic [swd_pkg::WORD_BITS-1:0] rx_word;
  logic rx_toggle;
  modport link (output rx_word, output rx_toggle);
  modport core (input rx_word, input rx_toggle);
endinterface : swd_link_if

// [design/swd_spi_link.sv]
module swd_spi_link (
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_select_low,
  input wire logic serial_in,
  output logic serial_out,
  swd_link_if.link lnk
);

  logic link_clr;
  logic [swd_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [swd_pkg::BIT_CNT_W-1:0] next_bit_cnt;
  logic [swd_pkg::BIT_CNT_W-1:0] out_cnt;
  logic [swd_pkg::BIT_CNT_W-1:0] next_out_cnt;
  logic [swd_pkg::WORD_BITS-1:0] shift;
  logic [swd_pkg::WORD_BITS-1:0] next_shift;
  logic [swd_pkg::WORD_BITS-1:0] word;
  logic [swd_pkg::WORD_BITS-1:0] next_word;
  logic tgl;
  logic next_tgl;
  logic next_serial_out;

  // sclk stands still between frames, so the frame's own select ends the count
  assign link_clr = frame_select_low | rst;
  assign lnk.rx_word = word;
  assign lnk.rx_toggle = tgl;

  always_comb begin
    next_shift = {shift[swd_pkg::WORD_BITS-2:0], serial_in};
    next_bit_cnt = bit_cnt + 1'h1;
    next_word = word;
    next_tgl = tgl;
    if (bit_cnt == swd_pkg::LAST_BIT) begin
      next_word = next_shift;
      next_tgl = ~tgl;
    end
  end

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      word <= '0;
      tgl <= 1'h0;
    end else begin
      word <= next_word;
      tgl <= next_tgl;
    end
  end

  always_ff @(negedge sclk) begin
    shift <= next_shift;
  end

  // echoes the previous word, msb first, so longer frames pass words down a chain
  always_comb begin
    next_serial_out = word[swd_pkg::LAST_BIT - out_cnt];
    next_out_cnt = out_cnt + 1'h1;
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      out_cnt <= '0;
      serial_out <= 1'h0;
    end else begin
      out_cnt <= next_out_cnt;
      serial_out <= next_serial_out;
    end
  end

endmodule : swd_spi_link

// [tb/swd_host_model.sv]
module swd_host_model (
  output logic sclk,
  output logic frame_select_low,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx;
  initial begin
    sclk = 1'b0;
    frame_select_low = 1'b1;
    serial_in = 1'b0;
    rx = 16'h0000;
  end
  // sclk stands low between frames; phase offset keeps it apart from the core clock
  task automatic xfer(input logic [15:0] w);
    #3.7 frame_select_low = 1'b0;
    #500;
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #31.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      rx = {rx[14:0], serial_out};
      #31;
    end
    #60 frame_select_low = 1'b1;
    serial_in = ~serial_in;
    #1000;
  endtask : xfer
endmodule : swd_host_model

// [tb/swd_top_props.sv]
module swd_top_props #(
  parameter int LOW_TIME_CYC = 200,
  parameter int LINK_LOSS_CYC = 300
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic active_low_device_reset,
  input wire logic frame_select_low,
  input wire logic [1:0] direct_in,
  input wire logic [1:0] over_current,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic [1:0] high_side_outputs,
  input wire logic fail_safe_mode,
  input wire logic sleep_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int hi_cnt;
  int lo_cnt;
  int rl_cnt;
  always_ff @(posedge clk) begin
    if (rst || !active_low_device_reset) hi_cnt <= 0;
    else if (hi_cnt < LINK_LOSS_CYC + 8) hi_cnt <= hi_cnt + 1;
    // inputs may have gone low long before the pin did, so the pin does not restart this count
    if (rst || direct_in != 2'h0) lo_cnt <= 0;
    else if (lo_cnt < LOW_TIME_CYC + 8) lo_cnt <= lo_cnt + 1;
    if (rst || active_low_device_reset) rl_cnt <= 0;
    else if (rl_cnt < 1100) rl_cnt <= rl_cnt + 1;
  end
  AST_SEL_DRIVES: assert property ($fell(frame_select_low) |-> ##[1:4] serial_out_en)
    else $error("output not enabled after select");
  AST_SEL_RELEASES: assert property ($rose(frame_select_low) |-> ##[1:4] !serial_out_en)
    else $error("output not released after select");
  AST_IDLE_QUIET: assert property (frame_select_low [*5] |-> !serial_out_en && !serial_out)
    else $error("output active while deselected");
  AST_FS_NOT_EARLY: assert property ($rose(fail_safe_mode) |-> hi_cnt >= LINK_LOSS_CYC)
    else $error("fail-safe before link loss interval");
  AST_FS_LEFT: assert property (!active_low_device_reset [*6] |-> !fail_safe_mode)
    else $error("fail-safe kept under device reset");
  AST_FS_OUTPUTS: assert property ((fail_safe_mode && direct_in == 2'h0) [*5] |-> high_side_outputs == 2'h0)
    else $error("fail-safe outputs not from direct inputs");
  AST_SLEEP_NOT_EARLY: assert property ($rose(sleep_mode) |-> lo_cnt >= LOW_TIME_CYC)
    else $error("sleep too early");
  AST_SLEEP_ON_TIME: assert property (lo_cnt >= LOW_TIME_CYC + 6 && rl_cnt >= 4 |-> sleep_mode)
    else $error("sleep missing");
  AST_SLEEP_OFF: assert property (sleep_mode [*2] |-> high_side_outputs == 2'h0)
    else $error("outputs on in sleep");
  AST_LONG_RESET: assert property ((rl_cnt >= 1010 && !direct_in[0]) [*5] |-> !high_side_outputs[0])
    else $error("channel on after long reset");
  AST_OC_CUTS: assert property (over_current[0] [*5] |-> !high_side_outputs[0])
    else $error("channel on during over-current");
  COV_FS: cover property ($rose(fail_safe_mode));
  COV_SLEEP: cover property ($rose(sleep_mode));
  COV_FRAME: cover property ($rose(serial_out_en));
endmodule : swd_top_props

bind swd_top swd_top_props #(.LOW_TIME_CYC(LOW_TIME_CYC), .LINK_LOSS_CYC(LINK_LOSS_CYC)) u_props (
  .clk(clk),
  .rst(rst),
  .active_low_device_reset(active_low_device_reset),
  .frame_select_low(frame_select_low),
  .direct_in(direct_in),
  .over_current(over_current),
  .serial_out(serial_out),
  .serial_out_en(serial_out_en),
  .high_side_outputs(high_side_outputs),
  .fail_safe_mode(fail_safe_mode),
  .sleep_mode(sleep_mode)
);

// [tb/tb_spi_watchdog_retry_timing.sv]
module tb_spi_watchdog_retry_timing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOW_CYC = 200;
  localparam int LOSS_CYC = 2000;
  localparam int RETRY_CYC [4] = '{80, 40, 20, 10};
  logic clk, rst, active_low_device_reset, so, so_en, fs, slp, toggle, sclk, frame_select_low, serial_in;
  logic [1:0] direct_in, over_current, hs;
  int mismatches, num_checks, n;
  swd_top #(.LOW_TIME_CYC(LOW_CYC), .LINK_LOSS_CYC(LOSS_CYC), .RETRY_CYC_00(80), .RETRY_CYC_01(40),
    .RETRY_CYC_10(20), .RETRY_CYC_11(10)) dut (.clk(clk), .rst(rst),
    .active_low_device_reset(active_low_device_reset), .sclk(sclk), .frame_select_low(frame_select_low),
    .serial_in(serial_in), .direct_in(direct_in), .over_current(over_current), .serial_out(so),
    .serial_out_en(so_en), .high_side_outputs(hs), .fail_safe_mode(fs), .sleep_mode(slp));
  swd_host_model host (.sclk(sclk), .frame_select_low(frame_select_low), .serial_in(serial_in), .serial_out(so));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc
  // cfg: [1:0] channel on, [2] watchdog off, [3] retry on, [5:4] retry period
  task automatic word(input logic [5:0] cfg);
    toggle = ~toggle;
    host.xfer({toggle, 3'h0, 6'h00, cfg});
    cyc(6);
  endtask : word
  task automatic pin_pulse(input int c);
    active_low_device_reset = 1'b0;
    cyc(c);
    active_low_device_reset = 1'b1;
    toggle = 1'b0;
    cyc(510);
  endtask : pin_pulse
  task automatic t_sleep_echo_loss;
    cyc(LOW_CYC - 20);
    check({15'h0, slp}, 16'h0000);
    cyc(40);
    check({15'h0, slp}, 16'h0001);
    pin_pulse(0);
    word(6'h03);
    check({14'h0, hs}, 16'h0003);
    word(6'h01);
    check(host.rx, 16'h8003);
    check({14'h0, hs}, 16'h0001);
    cyc(LOSS_CYC - 200);
    check({15'h0, fs}, 16'h0000);
    cyc(200);
    check({14'h0, fs, hs[0]}, 16'h0002);
    direct_in = 2'h2;
    cyc(6);
    check({14'h0, hs}, 16'h0002);
  endtask : t_sleep_echo_loss
  task automatic t_toggle_stuck;
    direct_in = 2'h0;
    pin_pulse(20);
    repeat (7) host.xfer(16'h8001);
    cyc(2);
    check({15'h0, fs}, 16'h0001);
  endtask : t_toggle_stuck
  task automatic t_disable;
    pin_pulse(20);
    word(6'h04);
    cyc(LOSS_CYC + 200);
    check({15'h0, fs}, 16'h0000);
    pin_pulse(1100);
    cyc(LOSS_CYC);
    check({15'h0, fs}, 16'h0001);
  endtask : t_disable
  task automatic t_long_reset;
    pin_pulse(20);
    direct_in = 2'h2;
    word(6'h01);
    check({14'h0, hs}, 16'h0003);
    active_low_device_reset = 1'b0;
    cyc(500);
    check({14'h0, hs}, 16'h0003);
    cyc(600);
    check({14'h0, hs}, 16'h0002);
    pin_pulse(0);
  endtask : t_long_reset
  task automatic t_retry;
    // input held high so the low timer cannot delatch the fault before the retry does
    direct_in = 2'h1;
    for (int p = 0; p < 4; p++) begin
      word({p[1:0], 1'b1, 1'b0, 2'h1});
      over_current = 2'h1;
      cyc(2);
      over_current = 2'h0;
      cyc(4);
      check({15'h0, hs[0]}, 16'h0000);
      n = 6;
      while (!hs[0] && n < 400) begin
        cyc(1);
        n++;
      end
      check({15'h0, n >= RETRY_CYC[p] && n <= RETRY_CYC[p] + 12}, 16'h0001);
    end
  endtask : t_retry
  task automatic t_delatch;
    word(6'h00);
    direct_in = 2'h1;
    cyc(6);
    over_current = 2'h1;
    cyc(6);
    over_current = 2'h0;
    cyc(LOW_CYC);
    check({15'h0, hs[0]}, 16'h0000);
    direct_in = 2'h0;
    cyc(LOW_CYC + 10);
    direct_in = 2'h1;
    cyc(6);
    check({15'h0, hs[0]}, 16'h0001);
    // a word for another register must leave the channel bits alone
    toggle = ~toggle;
    host.xfer({toggle, 3'h1, 12'h003});
    cyc(6);
    check({14'h0, hs}, 16'h0001);
  endtask : t_delatch
  initial begin
    rst = 1'b1;
    active_low_device_reset = 1'b0;
    direct_in = 2'h0;
    over_current = 2'h0;
    toggle = 1'b0;
    mismatches = 0;
    num_checks = 0;
    cyc(4);
    rst = 1'b0;
    t_sleep_echo_loss();
    t_toggle_stuck();
    t_disable();
    t_long_reset();
    t_retry();
    t_delatch();
    tally_and_finish();
  end
  // whole sequence needs well under this span
  initial begin
    #600000;
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_spi_watchdog_retry_timing
